// ==== pkg/phase_timing_pkg.sv ====
// Register map, field layout and carrier types for the phase timing block
package phase_timing_pkg;
  localparam logic [7:0] ADDR_AMB2_CONV_START = 8'h0f;
  localparam logic [7:0] ADDR_AMB2_CONV_END = 8'h10;
  localparam logic [7:0] ADDR_LED1_CONV_START = 8'h11;
  localparam logic [7:0] ADDR_LED1_CONV_END = 8'h12;
  localparam logic [7:0] ADDR_AMB1_CONV_START = 8'h13;
  localparam logic [7:0] ADDR_AMB1_CONV_END = 8'h14;
  localparam logic [7:0] ADDR_REP_PERIOD = 8'h1d;
  localparam logic [7:0] ADDR_ENGINE_AVG = 8'h1e;
  localparam logic [7:0] ADDR_GAIN_SET34 = 8'h1f;
  localparam logic [7:0] ADDR_GAIN_SET2 = 8'h20;
  localparam logic [7:0] ADDR_PRIMARY_GAIN = 8'h21;
  localparam logic [7:0] ADDR_CONTROL0 = 8'h00;
  localparam logic [7:0] ADDR_CONTROL23 = 8'h23;
  localparam int ENGINE_ON_BIT = 8;
  localparam int AVG_LSB = 0;
  localparam int TWO_SET_BIT = 15;
  localparam int FOUR_PHASE_BIT = 15;
  localparam int HOLD_BIT = 1;
  localparam int OSC_SEL_BIT = 9;
  localparam int DAC_RANGE_LSB = 12;
  localparam int SET_HI_LSB = 8;
  localparam int RES_TOP_OFS = 6;
  localparam int CAP_OFS = 3;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [23:0] REG_RESET = 24'h000000;
  typedef enum logic [1:0] {
    PH_LED2 = 2'b00,
    PH_LED3_AMB2 = 2'b01,
    PH_LED1 = 2'b10,
    PH_AMB1 = 2'b11
  } phase_t;
  typedef struct packed {
    logic [3:0] res_code;
    logic [2:0] cap_code;
  } gain_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] wdata;
    logic wr;
  } reg_req_t;
endpackage

// ==== src/phase_timing_and_gain_select.sv ====
// Phase timing registers, repetition counter and per-phase gain selection
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Hold 16-bit start and end counts for the Ambient2/LED3 conversion phase
// - Hold 16-bit start and end counts for the LED1 conversion phase
// - Hold 16-bit start and end counts for the Ambient1 conversion phase
// - Repetition counter counts to terminal value then wraps to zero
// - Engine enable bit 8 turns the timer on when set
// - Enabled engine derives phase signals from programmed counts
// - Averaging field bits 3..0 gives field plus one conversions
// - Two-set gain bit 15 allows two independent gain groups
// - Two-set mode: alternate codes apply in LED2 and LED3/Ambient2
// - Four-phase mode: alternate codes apply only in LED2
// - Four-phase mode: bits 14..8 codes apply in Ambient1
// - Four-phase mode: bits 6..0 codes apply in LED3/Ambient2
// - Resistor code is separate top bit over 3-bit low; capacitor 3-bit
// - Bits 14..12 select offset DAC full-scale range
// - All counts, enable, averaging and gain fields reset to zero
// - Both modes clear: primary codes apply in all four phases
// - Four-phase mode: primary codes apply only in LED1
// - Counter-hold bit 1 keeps the repetition counter at zero
// - Oscillator select bit 9 only drives INTERNAL_OSC_SELECT; engine always runs on CORE_CLK
module phase_timing_and_gain_select #(
  parameter int COUNT_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire logic [23:0] REG_WDATA,
  output logic [23:0] REG_RDATA,
  output logic [COUNT_W-1:0] PERIOD_COUNT,
  output logic LED1_CONV,
  output logic AMB1_CONV,
  output logic AMB2_LED3_CONV,
  output logic LED2_CONV,
  output logic [1:0] ACTIVE_PHASE,
  output logic [3:0] RES_CODE,
  output logic [2:0] CAP_CODE,
  output logic [3:0] AVERAGE_COUNT_MINUS_ONE,
  output logic [2:0] OFFSET_DAC_RANGE,
  output logic INTERNAL_OSC_SELECT
);
  logic [15:0] amb2_led3_conv_start_q, amb2_led3_conv_end_q;
  logic [15:0] first_emitter_conv_start_q, first_emitter_conv_end_q;
  logic [15:0] first_ambient_conv_start_q, first_ambient_conv_end_q;
  logic [15:0] repetition_terminal_count_q;
  logic timing_engine_on_q, two_set_gain_mode_q, four_phase_gain_mode_q;
  logic counter_hold_q, internal_osc_select_q;
  logic [3:0] average_count_minus_one_q;
  logic [13:0] set34_q;
  logic [6:0] set2_q, primary_q;
  logic [2:0] offset_dac_range_q;
  logic [COUNT_W-1:0] count_q, count_d;
  logic led1_q, amb1_q, amb2_q, led2_q;
  logic [1:0] phase_q;
  phase_timing_pkg::gain_t gain_q, gain_d;
  phase_timing_pkg::reg_req_t req;
  phase_timing_pkg::gain_t g_primary, g_set2, g_set3, g_set4;

  function automatic phase_timing_pkg::gain_t unpack_gain(input logic [6:0] f);
    unpack_gain.res_code = {f[phase_timing_pkg::RES_TOP_OFS], f[2:0]};
    unpack_gain.cap_code = f[phase_timing_pkg::CAP_OFS +: 3];
  endfunction

  function automatic logic in_window(input logic [COUNT_W-1:0] c,
                                     input logic [15:0] s, input logic [15:0] e);
    in_window = (c >= COUNT_W'(s)) && (c <= COUNT_W'(e));
  endfunction

  assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR};
  wire wr_amb2s = req.wr && req.addr == phase_timing_pkg::ADDR_AMB2_CONV_START;
  wire wr_amb2e = req.wr && req.addr == phase_timing_pkg::ADDR_AMB2_CONV_END;
  wire wr_led1s = req.wr && req.addr == phase_timing_pkg::ADDR_LED1_CONV_START;
  wire wr_led1e = req.wr && req.addr == phase_timing_pkg::ADDR_LED1_CONV_END;
  wire wr_amb1s = req.wr && req.addr == phase_timing_pkg::ADDR_AMB1_CONV_START;
  wire wr_amb1e = req.wr && req.addr == phase_timing_pkg::ADDR_AMB1_CONV_END;
  wire wr_rep = req.wr && req.addr == phase_timing_pkg::ADDR_REP_PERIOD;
  wire wr_eng = req.wr && req.addr == phase_timing_pkg::ADDR_ENGINE_AVG;
  wire wr_g34 = req.wr && req.addr == phase_timing_pkg::ADDR_GAIN_SET34;
  wire wr_g2 = req.wr && req.addr == phase_timing_pkg::ADDR_GAIN_SET2;
  wire wr_gp = req.wr && req.addr == phase_timing_pkg::ADDR_PRIMARY_GAIN;
  wire wr_c0 = req.wr && req.addr == phase_timing_pkg::ADDR_CONTROL0;
  wire wr_c23 = req.wr && req.addr == phase_timing_pkg::ADDR_CONTROL23;

  // Register file, all fields clear on reset
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      amb2_led3_conv_start_q <= phase_timing_pkg::COUNT_RESET;
      amb2_led3_conv_end_q <= phase_timing_pkg::COUNT_RESET;
      first_emitter_conv_start_q <= phase_timing_pkg::COUNT_RESET;
      first_emitter_conv_end_q <= phase_timing_pkg::COUNT_RESET;
      first_ambient_conv_start_q <= phase_timing_pkg::COUNT_RESET;
      first_ambient_conv_end_q <= phase_timing_pkg::COUNT_RESET;
      repetition_terminal_count_q <= phase_timing_pkg::COUNT_RESET;
      timing_engine_on_q <= 1'b0;
      average_count_minus_one_q <= 4'h0;
      set34_q <= 14'h0000;
      set2_q <= 7'h00;
      primary_q <= 7'h00;
      two_set_gain_mode_q <= 1'b0;
      four_phase_gain_mode_q <= 1'b0;
      offset_dac_range_q <= 3'h0;
      counter_hold_q <= 1'b0;
      internal_osc_select_q <= 1'b0;
    end else begin
      if (wr_amb2s) amb2_led3_conv_start_q <= req.wdata[15:0];
      if (wr_amb2e) amb2_led3_conv_end_q <= req.wdata[15:0];
      if (wr_led1s) first_emitter_conv_start_q <= req.wdata[15:0];
      if (wr_led1e) first_emitter_conv_end_q <= req.wdata[15:0];
      if (wr_amb1s) first_ambient_conv_start_q <= req.wdata[15:0];
      if (wr_amb1e) first_ambient_conv_end_q <= req.wdata[15:0];
      if (wr_rep) repetition_terminal_count_q <= req.wdata[15:0];
      if (wr_eng) begin
        timing_engine_on_q <= req.wdata[phase_timing_pkg::ENGINE_ON_BIT];
        average_count_minus_one_q <= req.wdata[phase_timing_pkg::AVG_LSB +: 4];
      end
      if (wr_g34) set34_q <= {req.wdata[14:8], req.wdata[6:0]};
      if (wr_g2) begin
        two_set_gain_mode_q <= req.wdata[phase_timing_pkg::TWO_SET_BIT];
        set2_q <= req.wdata[6:0];
      end
      if (wr_gp) begin
        primary_q <= req.wdata[6:0];
        offset_dac_range_q <= req.wdata[phase_timing_pkg::DAC_RANGE_LSB +: 3];
      end
      if (wr_c0) counter_hold_q <= req.wdata[phase_timing_pkg::HOLD_BIT];
      if (wr_c23) begin
        four_phase_gain_mode_q <= req.wdata[phase_timing_pkg::FOUR_PHASE_BIT];
        internal_osc_select_q <= req.wdata[phase_timing_pkg::OSC_SEL_BIT];
      end
    end
  end

  // Readback of the addressed register; CONTROL0 (0x00) and CONTROL23 (0x23) read as zero
  always_comb begin
    REG_RDATA = phase_timing_pkg::REG_RESET;
    case (REG_ADDR)
      phase_timing_pkg::ADDR_AMB2_CONV_START: REG_RDATA[15:0] = amb2_led3_conv_start_q;
      phase_timing_pkg::ADDR_AMB2_CONV_END: REG_RDATA[15:0] = amb2_led3_conv_end_q;
      phase_timing_pkg::ADDR_LED1_CONV_START: REG_RDATA[15:0] = first_emitter_conv_start_q;
      phase_timing_pkg::ADDR_LED1_CONV_END: REG_RDATA[15:0] = first_emitter_conv_end_q;
      phase_timing_pkg::ADDR_AMB1_CONV_START: REG_RDATA[15:0] = first_ambient_conv_start_q;
      phase_timing_pkg::ADDR_AMB1_CONV_END: REG_RDATA[15:0] = first_ambient_conv_end_q;
      phase_timing_pkg::ADDR_REP_PERIOD: REG_RDATA[15:0] = repetition_terminal_count_q;
      phase_timing_pkg::ADDR_ENGINE_AVG: begin
        REG_RDATA[8] = timing_engine_on_q;
        REG_RDATA[3:0] = average_count_minus_one_q;
      end
      phase_timing_pkg::ADDR_GAIN_SET34: REG_RDATA[14:0] = {set34_q[13:7], 1'b0, set34_q[6:0]};
      phase_timing_pkg::ADDR_GAIN_SET2: begin
        REG_RDATA[15] = two_set_gain_mode_q;
        REG_RDATA[6:0] = set2_q;
      end
      phase_timing_pkg::ADDR_PRIMARY_GAIN: begin
        REG_RDATA[14:12] = offset_dac_range_q;
        REG_RDATA[6:0] = primary_q;
      end
      default: REG_RDATA = phase_timing_pkg::REG_RESET;
    endcase
  end

  // Repetition counter
  always_comb begin
    if (!timing_engine_on_q || counter_hold_q) begin
      count_d = '0;
    end else if (count_q >= COUNT_W'(repetition_terminal_count_q)) begin
      count_d = '0;
    end else begin
      count_d = count_q + COUNT_W'(1);
    end
  end

  // Per-phase gain selection
  assign g_primary = unpack_gain(primary_q);
  assign g_set2 = unpack_gain(set2_q);
  assign g_set3 = unpack_gain(set34_q[13:7]);
  assign g_set4 = unpack_gain(set34_q[6:0]);
  always_comb begin
    gain_d = g_primary;
    if (four_phase_gain_mode_q) begin
      case (phase_q)
        phase_timing_pkg::PH_LED1: gain_d = g_primary;
        phase_timing_pkg::PH_LED2: gain_d = g_set2;
        phase_timing_pkg::PH_AMB1: gain_d = g_set3;
        phase_timing_pkg::PH_LED3_AMB2: gain_d = g_set4;
        default: gain_d = g_primary;
      endcase
    end else if (two_set_gain_mode_q) begin
      case (phase_q)
        phase_timing_pkg::PH_LED2: gain_d = g_set2;
        phase_timing_pkg::PH_LED3_AMB2: gain_d = g_set2;
        default: gain_d = g_primary;
      endcase
    end
  end

  // Phase windows and current phase
  wire run = timing_engine_on_q && !counter_hold_q;
  wire led1_w = run && in_window(count_q, first_emitter_conv_start_q, first_emitter_conv_end_q);
  wire amb1_w = run && in_window(count_q, first_ambient_conv_start_q, first_ambient_conv_end_q);
  wire amb2_w = run && in_window(count_q, amb2_led3_conv_start_q, amb2_led3_conv_end_q);
  wire led2_w = run && !led1_w && !amb1_w && !amb2_w;
  wire [1:0] phase_d = led1_w ? phase_timing_pkg::PH_LED1 :
                       amb1_w ? phase_timing_pkg::PH_AMB1 :
                       amb2_w ? phase_timing_pkg::PH_LED3_AMB2 : phase_q;

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count_q <= '0;
      led1_q <= 1'b0;
      amb1_q <= 1'b0;
      amb2_q <= 1'b0;
      led2_q <= 1'b0;
      phase_q <= phase_timing_pkg::PH_LED2;
      gain_q <= '0;
    end else begin
      count_q <= count_d;
      led1_q <= led1_w;
      amb1_q <= amb1_w;
      amb2_q <= amb2_w;
      led2_q <= led2_w;
      phase_q <= led2_w ? phase_timing_pkg::PH_LED2 : phase_d;
      gain_q <= gain_d;
    end
  end

  assign PERIOD_COUNT = count_q;
  assign LED1_CONV = led1_q;
  assign AMB1_CONV = amb1_q;
  assign AMB2_LED3_CONV = amb2_q;
  assign LED2_CONV = led2_q;
  assign ACTIVE_PHASE = phase_q;
  assign RES_CODE = gain_q.res_code;
  assign CAP_CODE = gain_q.cap_code;
  assign AVERAGE_COUNT_MINUS_ONE = average_count_minus_one_q;
  assign OFFSET_DAC_RANGE = offset_dac_range_q;
  assign INTERNAL_OSC_SELECT = internal_osc_select_q;

  sequence wrap_s;
    count_q == COUNT_W'(repetition_terminal_count_q) && run;
  endsequence
  counter_wraps_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wrap_s ##0 $stable(repetition_terminal_count_q) |=> count_q == '0)
    else $error("counter did not wrap");
  hold_keeps_zero_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    counter_hold_q |=> count_q == '0) else $error("held counter moved");
  engine_off_idle_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !timing_engine_on_q |=> count_q == '0 && !led1_q) else $error("engine off but active");
  led1_window_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    led1_w |=> LED1_CONV) else $error("led1 window missed");
  four_phase_amb1_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    four_phase_gain_mode_q && phase_q == phase_timing_pkg::PH_AMB1 |=> RES_CODE ==
    {$past(set34_q[13]), $past(set34_q[9:7])}) else $error("ambient1 gain wrong");
  two_set_led2_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !four_phase_gain_mode_q && two_set_gain_mode_q && phase_q == phase_timing_pkg::PH_LED2
    |=> CAP_CODE == $past(set2_q[5:3])) else $error("two-set gain wrong");
  primary_default_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !four_phase_gain_mode_q && !two_set_gain_mode_q |=> CAP_CODE == $past(primary_q[5:3]))
    else $error("primary gain wrong");
  avg_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_eng |=> AVERAGE_COUNT_MINUS_ONE == $past(REG_WDATA[3:0])) else $error("avg not stored");
  sequence four_phase_s;
    four_phase_gain_mode_q;
  endsequence
  sequence two_set_only_s;
    !four_phase_gain_mode_q && two_set_gain_mode_q;
  endsequence
  four_phase_led2_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    four_phase_s ##0 phase_q == phase_timing_pkg::PH_LED2 |=> {RES_CODE, CAP_CODE} ==
    $past({set2_q[6], set2_q[2:0], set2_q[5:3]})) else $error("led2 gain wrong");
  four_phase_amb2_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    four_phase_s ##0 phase_q == phase_timing_pkg::PH_LED3_AMB2 |=> {RES_CODE, CAP_CODE} ==
    $past({set34_q[6], set34_q[2:0], set34_q[5:3]})) else $error("ambient2 gain wrong");
  four_phase_led1_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    four_phase_s ##0 phase_q == phase_timing_pkg::PH_LED1 |=> {RES_CODE, CAP_CODE} ==
    $past({primary_q[6], primary_q[2:0], primary_q[5:3]})) else $error("led1 gain wrong");
  mode_precedence_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    four_phase_s ##0 two_set_gain_mode_q && phase_q == phase_timing_pkg::PH_LED3_AMB2
    |=> CAP_CODE == $past(set34_q[5:3])) else $error("gain mode precedence wrong");
  two_set_amb2_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    two_set_only_s ##0 phase_q == phase_timing_pkg::PH_LED3_AMB2
    |=> RES_CODE == $past({set2_q[6], set2_q[2:0]})) else $error("two-set ambient2 wrong");
  two_set_led1_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    two_set_only_s ##0 phase_q == phase_timing_pkg::PH_LED1
    |=> RES_CODE == $past({primary_q[6], primary_q[2:0]})) else $error("two-set led1 wrong");
  amb1_window_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    amb1_w |=> AMB1_CONV) else $error("ambient1 window missed");
  amb2_window_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    amb2_w |=> AMB2_LED3_CONV) else $error("ambient2 window missed");
  led2_phase_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    led2_w |=> LED2_CONV && ACTIVE_PHASE == phase_timing_pkg::PH_LED2)
    else $error("led2 phase missed");
  dac_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_gp |=> OFFSET_DAC_RANGE == $past(REG_WDATA[phase_timing_pkg::DAC_RANGE_LSB +: 3]))
    else $error("dac range not stored");
  osc_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    wr_c23 |=> INTERNAL_OSC_SELECT == $past(REG_WDATA[phase_timing_pkg::OSC_SEL_BIT]))
    else $error("osc select not stored");
  count_step_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    run && count_q < COUNT_W'(repetition_terminal_count_q) |=>
    count_q == $past(count_q) + COUNT_W'(1)) else $error("counter did not advance");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Host-side register write model for the phase timing block
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic CORE_CLK,
  output logic REG_WR,
  output logic [7:0] REG_ADDR,
  output logic [23:0] REG_WDATA
);
  initial begin
    REG_WR = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 24'h000000;
  end
  // One-cycle write strobe; unused bits cleared by the mask
  task automatic write_reg(input logic [7:0] a, input logic [23:0] d, input logic [23:0] m);
    @(posedge CORE_CLK);
    #1;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d & m;
    @(posedge CORE_CLK);
    #1;
    REG_WR = 1'b0;
    REG_WDATA = ~REG_WDATA;
  endtask
  task automatic set_addr(input logic [7:0] a);
    @(posedge CORE_CLK);
    #1;
    REG_ADDR = a;
  endtask
endmodule
`default_nettype wire

// ==== tb/phase_timing_and_gain_select_tb.sv ====
// Self-checking testbench for the phase timing block
`timescale 1ns/10ps
`default_nettype none
module phase_timing_and_gain_select_tb;
  logic CORE_CLK, RESETN, REG_WR, LED1_CONV, AMB1_CONV, AMB2_LED3_CONV, LED2_CONV, osc_sel;
  logic [7:0] REG_ADDR;
  logic [23:0] REG_WDATA, REG_RDATA;
  logic [15:0] PERIOD_COUNT, prev_cnt, hold_cnt;
  logic [1:0] ACTIVE_PHASE, prev_ph, exp_ph;
  logic [3:0] RES_CODE, avg;
  logic [2:0] CAP_CODE, dac;
  int fail_count = 0;
  int checked = 0;
  logic [7:0] addrs [11] = '{8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h1d, 8'h1e, 8'h1f,
    8'h20, 8'h21};
  logic [23:0] masks [11] = '{24'h00ffff, 24'h00ffff, 24'h00ffff, 24'h00ffff, 24'h00ffff,
    24'h00ffff, 24'h00ffff, 24'h00010f, 24'h007f7f, 24'h00807f, 24'h00707f};
  host_model host (.CORE_CLK(CORE_CLK), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA));
  phase_timing_and_gain_select #(.COUNT_W(16)) dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .PERIOD_COUNT(PERIOD_COUNT), .LED1_CONV(LED1_CONV), .AMB1_CONV(AMB1_CONV),
    .AMB2_LED3_CONV(AMB2_LED3_CONV), .LED2_CONV(LED2_CONV), .ACTIVE_PHASE(ACTIVE_PHASE),
    .RES_CODE(RES_CODE), .CAP_CODE(CAP_CODE), .AVERAGE_COUNT_MINUS_ONE(avg),
    .OFFSET_DAC_RANGE(dac), .INTERNAL_OSC_SELECT(osc_sel));
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    host.set_addr(a);
    #1;
    chk(REG_RDATA, exp);
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Expected {res, cap}: primary 9/2, set2 2/3, set3 c/5, set4 7/6
  function automatic logic [6:0] exp_gain(input logic [1:0] m, input logic [1:0] ph);
    if (m[1]) begin
      case (ph)
        2'd0: return 7'h13;
        2'd1: return 7'h3e;
        2'd2: return 7'h4a;
        default: return 7'h65;
      endcase
    end else if (m[0] && ph[1] == 1'b0) begin
      return 7'h13;
    end
    return 7'h4a;
  endfunction
  function automatic logic [1:0] phase_of(input logic [15:0] c);
    if (c >= 16'd1 && c <= 16'd2) return 2'd2;
    if (c >= 16'd4 && c <= 16'd5) return 2'd3;
    if (c >= 16'd7 && c <= 16'd8) return 2'd1;
    return 2'd0;
  endfunction
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    fail_count++;
    end_of_test();
  end
  initial begin
    RESETN = 1'b0;
    repeat (10) @(posedge CORE_CLK);
    #1;
    RESETN = 1'b1;
    for (int i = 0; i < 11; i++) rd(addrs[i], 24'h000000);
    for (int i = 0; i < 11; i++) host.write_reg(addrs[i], 24'hffffff, masks[i]);
    for (int i = 0; i < 11; i++) rd(addrs[i], masks[i]);
    for (int i = 0; i < 11; i++) host.write_reg(addrs[i], 24'h5a5a5a, masks[i]);
    for (int i = 0; i < 11; i++) rd(addrs[i], 24'h5a5a5a & masks[i]);
    host.write_reg(8'h30, 24'h00ffff, 24'hffffff);
    rd(8'h30, 24'h000000);
    chk({20'h0, avg}, 24'h00000a);
    chk({21'h0, dac}, 24'h000005);
    host.write_reg(8'h0f, 24'h000007, 24'h00ffff);
    host.write_reg(8'h10, 24'h000008, 24'h00ffff);
    host.write_reg(8'h11, 24'h000001, 24'h00ffff);
    host.write_reg(8'h12, 24'h000002, 24'h00ffff);
    host.write_reg(8'h13, 24'h000004, 24'h00ffff);
    host.write_reg(8'h14, 24'h000005, 24'h00ffff);
    host.write_reg(8'h1d, 24'h00000a, 24'h00ffff);
    host.write_reg(8'h21, 24'h000051, 24'h00707f);
    host.write_reg(8'h1f, 24'h006c37, 24'h007f7f);
    host.write_reg(8'h1e, 24'h000100, 24'h00010f);
    for (int m = 0; m < 4; m++) begin
      host.write_reg(8'h20, {8'h0, m[0], 15'h001a}, 24'h00807f);
      host.write_reg(8'h23, {8'h0, m[1], 5'h0, m[1], 9'h0}, 24'h008200);
      chk({23'h0, osc_sel}, {23'h0, m[1]});
      for (int k = 0; k < 24; k++) begin
        @(posedge CORE_CLK);
        #2;
        if (k > 0) begin
          exp_ph = phase_of(prev_cnt);
          chk({8'h0, PERIOD_COUNT}, (prev_cnt >= 16'd10) ? 24'h0 : {8'h0, prev_cnt + 16'd1});
          chk({22'h0, ACTIVE_PHASE}, {22'h0, exp_ph});
          chk({20'h0, LED1_CONV, AMB1_CONV, AMB2_LED3_CONV, LED2_CONV},
            {20'h0, exp_ph == 2'd2, exp_ph == 2'd3, exp_ph == 2'd1, exp_ph == 2'd0});
          chk({17'h0, RES_CODE, CAP_CODE}, {17'h0, exp_gain(m[1:0], prev_ph)});
        end
        prev_cnt = PERIOD_COUNT;
        prev_ph = ACTIVE_PHASE;
      end
    end
    host.write_reg(8'h00, 24'h000002, 24'h000002);
    repeat (3) begin
      @(posedge CORE_CLK);
      #2;
      chk({8'h0, PERIOD_COUNT}, 24'h000000);
    end
    host.write_reg(8'h00, 24'h000000, 24'h000002);
    repeat (3) @(posedge CORE_CLK);
    #2;
    chk({23'h0, PERIOD_COUNT != 16'd0}, 24'h000001);
    host.write_reg(8'h1e, 24'h000000, 24'h00010f);
    hold_cnt = PERIOD_COUNT;
    chk({23'h0, hold_cnt != 16'd0}, 24'h000001);
    repeat (4) @(posedge CORE_CLK);
    #2;
    chk({8'h0, PERIOD_COUNT}, 24'h000000);
    end_of_test();
  end
endmodule
`default_nettype wire
